// >>> sim/acm_conv_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module acm_conv_ctrl_checker
   import acm_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire acm_cfg_t          cfg,
   input wire logic              start_req,
   input wire logic              filt_done,
   input wire logic [CODE_W-1:0] filt_code,
   input wire logic              filt_start,
   input wire logic              low_power,
   input wire logic              busy,
   input wire logic [CODE_W-1:0] latest_code,
   input wire logic              latest_valid,
   input wire logic [CODE_W-1:0] rd_data,
   input wire logic              rd_valid,
   input wire logic              rd_ready,
   input wire logic              overrun
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_start_answer: assert property (
      start_req && low_power |=> filt_start && busy) else $error("idle start not taken");
   a_start_pulse: assert property (
      filt_start |=> !filt_start) else $error("start pulse too long");
   a_latest_load: assert property (
      filt_done && busy |=> latest_valid && latest_code == $past(filt_code))
      else $error("latest result not loaded");
   a_latest_hold: assert property (
      !(filt_done && busy) |=> $stable(latest_code)) else $error("latest result moved");
   a_busy_end: assert property (
      filt_done && busy |=> !busy) else $error("busy after completion");
   a_single_idle: assert property (
      filt_done && busy && cfg.mode == ACM_SINGLE |=> low_power && !busy)
      else $error("single shot not idle");
   a_idle_hold: assert property (
      low_power && !start_req |=> low_power && !filt_start) else $error("left idle unasked");
   a_busy_hold: assert property (
      busy && !filt_done |=> busy) else $error("conversion dropped");
   a_stream_hold: assert property (
      rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("stream word moved");
   a_overrun_keep: assert property (
      overrun |=> overrun) else $error("overrun cleared");
endmodule
`default_nettype wire
bind acm_conv_ctrl acm_conv_ctrl_checker u_chk (.clock(clock), .rst_b(rst_b), .cfg(cfg),
   .start_req(start_req), .filt_done(filt_done), .filt_code(filt_code),
   .filt_start(filt_start), .low_power(low_power), .busy(busy), .latest_code(latest_code),
   .latest_valid(latest_valid), .rd_data(rd_data), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .overrun(overrun));

// >>> sim/acm_filter_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the converter's digital filter; latency set by lat (1 or more)
module acm_filter_model (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        filt_start,
   input  wire logic [7:0]  lat,
   input  wire logic [15:0] code_in,
   output var  logic        filt_done,
   output var  logic [15:0] filt_code
);
   logic [7:0] cnt_r; // Cycles left, 0 when idle
   ////////////////////////////////////////////////////////////////
   // Code settles within one conversion and is a whole word
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r     <= 8'h00;
         filt_done <= 1'b0;
         filt_code <= 16'h0000;
      end else begin
         filt_done <= (cnt_r == 8'h01);
         // Outside the done pulse the code is scrambled, never held
         filt_code <= (cnt_r == 8'h01) ? code_in : ~filt_code;
         if (filt_start) cnt_r <= lat;
         else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> sim/test_acm_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_acm_conv_ctrl
   import acm_pkg::*;
();
   logic        clock = 1'b0; // 250 MHz
   logic        rst_b, start_req, rd_ready, filt_done, filt_start, low_power, busy;
   logic        latest_valid, rd_valid, overrun;
   logic [15:0] code_in, filt_code, latest_code, rd_data;
   logic [7:0]  lat;         // Filter latency in cycles
   acm_cfg_t    cfg;
   int          err_total = 0;
   int          cmp_count = 0;
   int          starts = 0;   // Filter starts seen
   // Slot counts as if the clock ran at 1 MHz, so every rate fits a short run
   localparam int unsigned SIM_KHZ = 1000;
   always #2 clock = ~clock;
   always @(posedge clock) if (filt_start === 1'b1) starts++;
   acm_conv_ctrl #(.CLK_KHZ(SIM_KHZ)) dut (.clock(clock), .rst_b(rst_b), .cfg(cfg),
      .start_req(start_req),
      .filt_done(filt_done), .filt_code(filt_code), .filt_start(filt_start),
      .low_power(low_power), .busy(busy), .latest_code(latest_code),
      .latest_valid(latest_valid), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .overrun(overrun));
   acm_filter_model u_filt (.clock(clock), .rst_b(rst_b), .filt_start(filt_start),
      .lat(lat), .code_in(code_in), .filt_done(filt_done), .filt_code(filt_code));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Inputs change 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Bounded wait; longer than the slowest slot at the bench clock rate
   task automatic wait_hi(ref logic s);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 30000) begin
         cyc(1);
         k++;
      end
   endtask
   // Request held 3 cycles so the extra cycles must be ignored
   task automatic convert(input logic [15:0] code);
      code_in = code;
      start_req = 1'b1;
      cyc(3);
      start_req = 1'b0;
      wait_hi(filt_done);
      cyc(1);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_single;
      cfg = '{ACM_SINGLE, 3'h6};
      starts = 0;
      check(latest_valid, 1'b0);
      convert(16'h1234);
      check(latest_code, 16'h1234);
      check(latest_valid, 1'b1);
      check(low_power, 1'b1);
      check(starts, 1);
      cyc(1);
      check(rd_valid, 1'b1);
      check(rd_data, 16'h1234);
      rd_ready = 1'b1;
      cyc(1);
      rd_ready = 1'b0;
      cyc(20);
      check(starts, 1);
      check(rd_valid, 1'b0);
      $display("single shot test finished");
   endtask
   // Fill the stream past its depth, then drain in order
   task automatic t_overrun;
      for (int i = 0; i < FIFO_DEPTH + 2; i++) convert(16'hA000 + 16'(i));
      cyc(2);
      check(overrun, 1'b1);
      check(latest_code, 16'hA011);
      // Stage plus FIFO keep seventeen words; the eighteenth was dropped
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         wait_hi(rd_valid);
         check(rd_data, 16'hA000 + 16'(i));
         rd_ready = 1'b1;
         cyc(1);
         rd_ready = 1'b0;
      end
      rd_ready = 1'b1;
      cyc(6);
      check(rd_valid, 1'b0);
      $display("overrun test finished");
   endtask
   // Restart spacing equals one slot at every rate select; 7 acts as 6
   task automatic t_cont;
      realtime     t0;
      int unsigned sps [8];
      sps = '{RATE_SPS_0, RATE_SPS_1, RATE_SPS_2, RATE_SPS_3, RATE_SPS_4, RATE_SPS_5,
              RATE_SPS_6, RATE_SPS_6};
      for (int r = 0; r < 8; r++) begin
         cfg = '{ACM_CONTINUOUS, 3'(r)};
         code_in = 16'h5A5A;
         start_req = 1'b1;
         wait_hi(filt_start);
         start_req = 1'b0;
         t0 = $realtime;
         cyc(1);
         wait_hi(filt_start);
         check(int'(($realtime - t0) / 4.0), SIM_KHZ * 1000 / sps[r]);
         // Back to single mid-conversion: this result ends the run of restarts
         cfg.mode = ACM_SINGLE;
         code_in = 16'hC300 + 16'(r);
         wait_hi(filt_done);
         cyc(2);
         check(latest_code, 16'hC300 + 16'(r));
         check(low_power, 1'b1);
         check(busy, 1'b0);
      end
      $display("continuous test finished");
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog: whole run is about 48500 cycles, limit is 60000
   initial begin
      #240000;
      err_total++;
      complete_run();
   end
   initial begin
      cfg = '{ACM_SINGLE, RATE_SEL_RST};
      {rst_b, start_req, rd_ready} = 3'h0;
      code_in = 16'h0000;
      lat = 8'h05;
      cyc(20);
      rst_b = 1'b1;
      cyc(1);
      t_single();
      t_overrun();
      t_cont();
      complete_run();
   end
endmodule
`default_nettype wire

// >>> verilog/acm_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module acm_conv_ctrl
   import acm_pkg::*;
#(
   // Clock rate behind the slot counts; a bench may lower it to keep runs brief
   parameter int unsigned CLK_KHZ = CLOCK_KHZ
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire acm_cfg_t          cfg,
   input  wire logic              start_req,
   input  wire logic              filt_done,
   input  wire logic [CODE_W-1:0] filt_code,
   output var  logic              filt_start,
   output var  logic              low_power,
   output var  logic              busy,
   output var  logic [CODE_W-1:0] latest_code,
   output var  logic              latest_valid,
   output var  logic [CODE_W-1:0] rd_data,
   output var  logic              rd_valid,
   input  wire logic              rd_ready,
   output var  logic              overrun
);
   ////////////////////////////////////////////////////////////////////////
   // Rate table

   // Cycles per sample for one rate select
   // Counts scale with the clock parameter; division floors, so a slot may
   // come out a fraction of a cycle short of the ideal interval
   // Slowest rate at the full clock needs the whole interval counter width
   function automatic logic [INTV_W-1:0] rate_cycles(input logic [RATE_SEL_W-1:0] sel);
      logic [INTV_W-1:0] c;
      // Fallback keeps every path assigned
      c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_0);
      unique case (sel)
         3'h0: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_0);
         3'h1: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_1);
         3'h2: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_2);
         3'h3: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_3);
         3'h4: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_4);
         3'h5: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_5);
         3'h6: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_6);
         // Code 7 cannot arrive after the clamp; fastest rate if it did
         default: c = INTV_W'((CLK_KHZ * 1000) / RATE_SPS_6);
      endcase
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state

   // Idle is the low-power state, conv waits for the filter's done pulse,
   // wait holds off the restart until the sample slot has run out
   // Filter code is only trusted in conv
   typedef enum logic [1:0] {ACM_IDLE, ACM_CONV, ACM_WAIT} acm_state_t;

   acm_state_t        state_r;      // Sequencer state
   acm_state_t        state_nxt;    // Next state
   logic [INTV_W-1:0] intv_r;       // Cycles left in sample slot
   logic [INTV_W-1:0] intv_nxt;     // Next slot count
   logic              start_r;      // Filter start pulse
   logic [CODE_W-1:0] latest_r;     // Atomic result buffer
   logic              lvalid_r;     // Buffer holds a result
   logic              ovr_r;        // Result dropped, FIFO full
   logic              low_r;        // Low-power flag
   logic              busy_r;       // Conversion running
   logic [CODE_W-1:0] fifo_q;       // FIFO head word
   logic              fifo_v;       // FIFO head valid
   logic              fifo_rdy;     // FIFO accepts a word
   logic [CODE_W-1:0] rd_data_r;    // Output stage data
   logic              rd_valid_r;   // Output stage valid

   // Decode of mode, rate and state terms
   wire               is_cont   = (cfg.mode == ACM_CONTINUOUS);
   wire [RATE_SEL_W-1:0] sel_ok = (cfg.rate_sel > RATE_SEL_MAX) ? RATE_SEL_MAX
                                                                : cfg.rate_sel;
   wire [INTV_W-1:0]  slot_len  = rate_cycles(sel_ok);
   wire               slot_end  = (intv_r == '0);
   wire               take_res  = (state_r == ACM_CONV) && filt_done;
   wire               go_idle   = (state_r == ACM_IDLE) && start_req;
   // Output stage takes a word when empty or being read
   wire               out_take  = !rd_valid_r || rd_ready;

   // Next-state decode
   // The slot counter rests at zero once run out; a filter slower than the
   // slot therefore restarts at once, trading the exact rate for freshness
   always_comb begin
      // Hold state, count the slot down
      state_nxt = state_r;
      intv_nxt  = slot_end ? '0 : intv_r - 1'b1;
      unique case (state_r)
         ACM_IDLE: begin
            // Only a host request leaves the low-power state
            if (go_idle) begin
               state_nxt = ACM_CONV;
               // Slot starts with the conversion it paces
               intv_nxt  = slot_len - 1'b1;
            end
         end
         ACM_CONV: begin
            // Stay until the filter reports a settled code
            if (filt_done) begin
               // Single-shot drops to idle, continuous waits out the slot
               state_nxt = is_cont ? ACM_WAIT : ACM_IDLE;
            end
         end
         ACM_WAIT: begin
            // Result is out; wait for the slot to close
            if (!is_cont) begin
               // Mode switched to single: stop at once
               state_nxt = ACM_IDLE;
            end else if (slot_end) begin
               // No host request needed to restart
               state_nxt = ACM_CONV;
               intv_nxt  = slot_len - 1'b1;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // Reset lands in low-power idle
         state_r <= ACM_IDLE;
         intv_r  <= '0;
         start_r <= 1'b0;
         low_r   <= 1'b1;
         busy_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         intv_r  <= intv_nxt;
         // Start pulses for one cycle on entry to conv, so each start yields one code
         start_r <= (state_nxt == ACM_CONV) && (state_r != ACM_CONV);
         // Low power mirrors the idle state, registered for a clean pin
         low_r   <= (state_nxt == ACM_IDLE);
         // Busy mirrors the conversion state
         busy_r  <= (state_nxt == ACM_CONV);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result buffer

   // Whole word swaps in one edge so a reader never mixes two results
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // No result yet after reset
         latest_r <= CODE_RST;
         lvalid_r <= 1'b0;
      end else if (take_res) begin
         // Only a done pulse during a conversion is a result
         latest_r <= filt_code;
         lvalid_r <= 1'b1;
      end
   end

   // Sticky drop flag; the buffer still updates, only the stream loses one
   // No clear but reset, so a drop is never lost
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // Cleared only here
         ovr_r <= 1'b0;
      end else if (take_res && !fifo_rdy) begin
         ovr_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result stream

   // Stream copy of every result; a full FIFO drops only the new word
   // The output stage below adds one more word of slack
   acm_fifo #(
      .WIDTH (CODE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_data   (filt_code),
      .in_valid  (take_res),
      .in_ready  (fifo_rdy),
      .out_data  (fifo_q),
      .out_valid (fifo_v),
      .out_ready (out_take)
   );

   // Registered output stage keeps the stream ports on flip-flops
   // A word moves only when the stage is empty or read this cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // Empty stage after reset
         rd_data_r  <= CODE_RST;
         rd_valid_r <= 1'b0;
      end else if (out_take) begin
         rd_data_r  <= fifo_q;
         rd_valid_r <= fifo_v;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from registers

   assign filt_start   = start_r;
   assign low_power    = low_r;
   assign busy         = busy_r;
   assign latest_code  = latest_r;
   assign latest_valid = lvalid_r;
   assign rd_data      = rd_data_r;
   assign rd_valid     = rd_valid_r;
   assign overrun      = ovr_r;
endmodule
`default_nettype wire

// >>> verilog/acm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module acm_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage array
   logic [AW-1:0]    wr_ptr_r;      // Write index
   logic [AW-1:0]    rd_ptr_r;      // Read index
   logic [AW:0]      count_r;       // Words held
   wire              push;
   wire              pop;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         // Simultaneous push and pop leave the level unchanged
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// >>> verilog/acm_pkg.sv
package acm_pkg;
   // Clock rate in kHz, used to turn sample intervals into cycle counts
   localparam int unsigned CLOCK_KHZ      = 250000;
   // Code width of one result
   localparam int unsigned CODE_W         = 16;
   // Result FIFO shape
   localparam int unsigned FIFO_DEPTH     = 16;
   // Counts of configuration registers and host commands
   localparam int unsigned CFG_REG_COUNT  = 5;
   localparam int unsigned CMD_COUNT      = 6;
   // Turbo data rates in samples per second, index is the rate select
   localparam int unsigned RATE_SPS_0     = 40;
   localparam int unsigned RATE_SPS_1     = 90;
   localparam int unsigned RATE_SPS_2     = 180;
   localparam int unsigned RATE_SPS_3     = 350;
   localparam int unsigned RATE_SPS_4     = 660;
   localparam int unsigned RATE_SPS_5     = 1200;
   localparam int unsigned RATE_SPS_6     = 2000;
   localparam int unsigned RATE_SEL_W     = 3;
   localparam logic [2:0]  RATE_SEL_MAX   = 3'h6;
   // Reset values
   localparam logic [2:0]  RATE_SEL_RST   = 3'h0;
   localparam logic [15:0] CODE_RST       = 16'h0000;
   // Interval counter width, wide enough for the slowest rate
   localparam int unsigned INTV_W         = 23;

   // Conversion mode
   typedef enum logic {ACM_SINGLE, ACM_CONTINUOUS} acm_mode_t;

   // Host configuration carried as one bundle
   typedef struct packed {
      acm_mode_t            mode;
      logic [RATE_SEL_W-1:0] rate_sel;
   } acm_cfg_t;

   // One completed result
   typedef struct packed {
      logic [CODE_W-1:0] code;
   } acm_result_t;
endpackage
